// *** hdl/pmcg_top.v ***
// pmcg_top.v: power manager slice with peripheral bus c clock gates,
// clock ready/failure interrupt enables and flags, and the reset cause.
// assumes: Avalon-MM master on clk_i; reset cause strobes come from the
// reset controller and are held stable across the release of rst_i.
// Summary of operation
// - mask bits 8..11 gate timer units 0..3 clocks, one runs
// - mask bits 2..7 gate serial units 0..5 clocks, one runs
// - mask bit 1 gates the event router clock
// - mask bit 0 gates the access guard c clock
// - clear-register bit 1 one clears failure enable and its request
// - clear-register bit 0 one clears ready enable and its request
// - set-register bit 0 one sets the clock ready enable
// - both enable registers read shared state; enabled flag raises request
// - clock ready flag sets when cpu and bus clocks reach selection
// - writing one to clock ready flag clears it, zero keeps it
// - reset cause bit 0 marks power-on; reset value 0x01
// - reset cause bit 1 marks a core supply brownout reset
// - reset cause bit 2 marks an io supply brownout reset
// - reset cause bit 4 marks a pin reset
// - reset cause bit 5 marks a watchdog reset
// - reset cause bit 6 marks a software reset request
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pmcg_defines.vh"
module pmcg_top (
  input  wire        clk_i,
  input  wire        rst_i,
  // avalon-mm slave, word addressed by register index
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // clock status from the clock generator, asynchronous levels
  input  wire        clock_ready_i,
  input  wire        clock_failure_i,
  // reset cause strobes, held by the reset controller around rst_i
  input  wire        power_on_cause_i,
  input  wire        core_supply_brownout_i,
  input  wire        io_supply_brownout_i,
  input  wire        pin_reset_cause_i,
  input  wire        watchdog_cause_i,
  input  wire        software_reset_cause_i,
  // peripheral bus c clock enables
  output wire        access_guard_c_clk_en_o,
  output wire        event_router_clk_en_o,
  output wire [5:0]  serial_unit_clk_en_o,
  output wire [3:0]  timer_unit_clk_en_o,
  // interrupt outputs
  output wire        irq_request_o,
  output wire        evt_irq_o
);
  reg  [`PMCG_MASK_WIDTH-1:0] clk_mask;
  reg  [1:0]  irq_enable;
  reg  [1:0]  irq_flags;
  reg  [7:0]  last_reset_source;
  reg  [1:0]  evt_status;
  reg  [1:0]  evt_enable;
  reg         ack;
  reg         rc_pending;
  reg  [1:0]  status_d;
  wire [1:0]  status_s;
  wire        req;
  wire        wr_stb;
  wire        rd_stb;
  wire [7:0]  wb;
  wire [1:0]  rise;
  wire        wr_mask;
  wire        wr_iclr;
  wire        wr_iset;
  wire        wr_flag;
  wire        wr_eclr;
  wire        wr_een;

  // status levels cross into clk_i before any logic reads them
  pmcg_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({clock_failure_i, clock_ready_i}),
    .rst_val_i (2'h0),
    .q_o       (status_s)
  );

  // one wait cycle per access keeps the read data registered
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_stb            = avs_write_i & ack;
  assign rd_stb            = avs_read_i & ~ack;
  assign wb                = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
  assign wr_mask = wr_stb & (avs_address_i == `PMCG_IDX_BUS_C_MASK);
  assign wr_iclr = wr_stb & (avs_address_i == `PMCG_IDX_IRQ_ENABLE_CLEAR);
  assign wr_iset = wr_stb & (avs_address_i == `PMCG_IDX_IRQ_ENABLE_SET);
  assign wr_flag = wr_stb & (avs_address_i == `PMCG_IDX_IRQ_FLAGS);
  assign wr_eclr = wr_stb & (avs_address_i == `PMCG_IDX_EVT_CLEAR);
  assign wr_een  = wr_stb & (avs_address_i == `PMCG_IDX_EVT_ENABLE);
  assign rise    = status_s & ~status_d;

  // handshake phase toggle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // clock gate mask; byte lanes 0 and 1 carry the twelve bits
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_mask <= `PMCG_MASK_RESET;
    end else if (wr_mask) begin
      if (avs_byteenable_i[0]) begin
        clk_mask[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        clk_mask[11:8] <= avs_writedata_i[11:8];
      end
    end
  end

  // one lets the unit's bus clock run, zero stops it
  assign timer_unit_clk_en_o     = clk_mask[`PMCG_LSB_TIMER+3:`PMCG_LSB_TIMER];
  assign serial_unit_clk_en_o    = clk_mask[`PMCG_LSB_SERIAL+5:`PMCG_LSB_SERIAL];
  assign event_router_clk_en_o   = clk_mask[`PMCG_BIT_EVENT_ROUTER];
  assign access_guard_c_clk_en_o = clk_mask[`PMCG_BIT_ACCESS_GUARD_C];

  // shared enable state; set and clear writes go to separate addresses
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable <= `PMCG_IRQ_RESET;
    end else if (wr_iclr) begin
      irq_enable[`PMCG_BIT_CLOCK_FAILURE] <=
        irq_enable[`PMCG_BIT_CLOCK_FAILURE] & ~wb[`PMCG_BIT_CLOCK_FAILURE];
      irq_enable[`PMCG_BIT_CLOCK_READY] <=
        irq_enable[`PMCG_BIT_CLOCK_READY] & ~wb[`PMCG_BIT_CLOCK_READY];
    end else if (wr_iset) begin
      irq_enable[`PMCG_BIT_CLOCK_READY] <=
        irq_enable[`PMCG_BIT_CLOCK_READY] | wb[`PMCG_BIT_CLOCK_READY];
      irq_enable[`PMCG_BIT_CLOCK_FAILURE] <=
        irq_enable[`PMCG_BIT_CLOCK_FAILURE] | wb[`PMCG_BIT_CLOCK_FAILURE];
    end
  end

  // flags set on the rising status level; a set in the clear cycle wins
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_d  <= 2'h0;
      irq_flags <= `PMCG_IRQ_RESET;
    end else begin
      status_d <= status_s;
      irq_flags[`PMCG_BIT_CLOCK_READY] <= rise[`PMCG_EV_CLOCK_READY] |
        (irq_flags[`PMCG_BIT_CLOCK_READY] &
         ~(wr_flag & wb[`PMCG_BIT_CLOCK_READY]));
      irq_flags[`PMCG_BIT_CLOCK_FAILURE] <= rise[`PMCG_EV_CLOCK_FAILURE] |
        (irq_flags[`PMCG_BIT_CLOCK_FAILURE] &
         ~(wr_flag & wb[`PMCG_BIT_CLOCK_FAILURE]));
    end
  end

  // request withdrawn at once when its enable is cleared
  assign irq_request_o = |(irq_enable & irq_flags);

  // wrapper event block: sticky status, write-one clear, enable mask
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_status <= 2'h0;
      evt_enable <= 2'h0;
    end else begin
      evt_status <= rise | (evt_status & ~({2{wr_eclr}} & wb[1:0]));
      if (wr_een) begin
        evt_enable <= wb[1:0];
      end
    end
  end

  assign evt_irq_o = |(evt_status & evt_enable);

  // reset cause is caught at the first edge after release, not in reset,
  // since an async reset may only load a constant
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_pending        <= 1'b1;
      last_reset_source <= `PMCG_RC_RESET;
    end else if (rc_pending) begin
      rc_pending <= 1'b0;
      // priority keeps exactly one bit set when strobes overlap
      if (power_on_cause_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_POWER_ON;
      end else if (core_supply_brownout_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_CORE_BROWNOUT;
      end else if (io_supply_brownout_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_IO_BROWNOUT;
      end else if (pin_reset_cause_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_PIN;
      end else if (watchdog_cause_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_WATCHDOG;
      end else if (software_reset_cause_i) begin
        last_reset_source <= 8'h01 << `PMCG_RC_SOFTWARE;
      end else begin
        last_reset_source <= `PMCG_RC_RESET;
      end
    end
  end

  // read data registered in the wait cycle; unmapped reads return zero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (avs_address_i)
        `PMCG_IDX_BUS_C_MASK: begin
          avs_readdata_o <= {20'h0_0000, clk_mask};
        end
        `PMCG_IDX_IRQ_ENABLE_CLEAR, `PMCG_IDX_IRQ_ENABLE_SET: begin
          avs_readdata_o <= {30'h0000_0000, irq_enable};
        end
        `PMCG_IDX_IRQ_FLAGS: begin
          avs_readdata_o <= {30'h0000_0000, irq_flags};
        end
        `PMCG_IDX_LAST_RESET_SRC: begin
          avs_readdata_o <= {24'h00_0000, last_reset_source};
        end
        `PMCG_IDX_EVT_STATUS: begin
          avs_readdata_o <= {30'h0000_0000, evt_status};
        end
        `PMCG_IDX_EVT_ENABLE: begin
          avs_readdata_o <= {30'h0000_0000, evt_enable};
        end
        default: begin
          avs_readdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule

// *** hdl/pmcg_defines.vh ***
// pmcg_defines.vh: register offsets, field positions and reset values
// assumes: included by bare name from the power manager slice modules
`ifndef PMCG_DEFINES_VH
`define PMCG_DEFINES_VH
// register indices as printed; byte address is four times the index
`define PMCG_IDX_IRQ_ENABLE_CLEAR 8'h34
`define PMCG_IDX_IRQ_ENABLE_SET   8'h35
`define PMCG_IDX_IRQ_FLAGS        8'h36
`define PMCG_IDX_LAST_RESET_SRC   8'h38
// registers of our own for the clock mask and the wrapper interrupt block
`define PMCG_IDX_BUS_C_MASK       8'h20
`define PMCG_IDX_EVT_STATUS       8'h40
`define PMCG_IDX_EVT_CLEAR        8'h41
`define PMCG_IDX_EVT_ENABLE       8'h42
// clock mask fields
`define PMCG_MASK_WIDTH           12
`define PMCG_MASK_RESET           12'h000
`define PMCG_BIT_ACCESS_GUARD_C   0
`define PMCG_BIT_EVENT_ROUTER     1
`define PMCG_LSB_SERIAL           2
`define PMCG_LSB_TIMER            8
// interrupt enable and flag fields
`define PMCG_BIT_CLOCK_READY      0
`define PMCG_BIT_CLOCK_FAILURE    1
`define PMCG_IRQ_RESET            2'h0
// reset cause fields
`define PMCG_RC_POWER_ON          0
`define PMCG_RC_CORE_BROWNOUT     1
`define PMCG_RC_IO_BROWNOUT       2
`define PMCG_RC_PIN               4
`define PMCG_RC_WATCHDOG          5
`define PMCG_RC_SOFTWARE          6
`define PMCG_RC_RESET             8'h01
// wrapper event status bits
`define PMCG_EV_CLOCK_READY       0
`define PMCG_EV_CLOCK_FAILURE     1
`endif

// *** hdl/pmcg_sync.v ***
// pmcg_sync.v: two-stage synchroniser for a vector of level inputs
// assumes: inputs are asynchronous to clk_i; only the second stage is read
`timescale 1ns/1ps
module pmcg_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] d_i,
  input  wire [WIDTH-1:0] rst_val_i,
  output reg  [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= {WIDTH{1'b0}};
      q_o  <= {WIDTH{1'b0}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// *** test/pmcg_top_sva.sv ***
// port-level checker for the power manager slice
// assumes: bound to pmcg_top; one clock, async active-high reset
`timescale 1ns/1ps
module pmcg_top_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        clock_ready_i,
  input wire        clock_failure_i,
  input wire        access_guard_c_clk_en_o,
  input wire        event_router_clk_en_o,
  input wire [5:0]  serial_unit_clk_en_o,
  input wire [3:0]  timer_unit_clk_en_o,
  input wire        irq_request_o
);
  // a transfer completes where waitrequest is sampled low
  wire        wr = avs_write_i && !avs_waitrequest_o;
  wire        rd = avs_read_i && !avs_waitrequest_o;
  wire        wm = wr && avs_address_i == 8'h20;
  wire [11:0] gates = {timer_unit_clk_en_o, serial_unit_clk_en_o,
                       event_router_clk_en_o, access_guard_c_clk_en_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_TIMER:
    assert property (wm && avs_byteenable_i[1] |=> timer_unit_clk_en_o ==
      $past(avs_writedata_i[11:8])) else $error("timer gates wrong");
  AST_SERIAL:
    assert property (wm && avs_byteenable_i[0] |=> serial_unit_clk_en_o ==
      $past(avs_writedata_i[7:2])) else $error("serial gates wrong");
  AST_ROUTER:
    assert property (wm && avs_byteenable_i[0] |=> event_router_clk_en_o ==
      $past(avs_writedata_i[1])) else $error("router gate wrong");
  AST_GUARD:
    assert property (wm && avs_byteenable_i[0] |=> access_guard_c_clk_en_o ==
      $past(avs_writedata_i[0])) else $error("guard gate wrong");
  AST_HOLD:
    assert property (!wm |=> $stable(gates)) else $error("gates moved");
  AST_CLR:
    assert property (wr && avs_address_i == 8'h34 && avs_byteenable_i[0]
      && avs_writedata_i[1:0] == 2'h3 |=> !irq_request_o)
      else $error("request not withdrawn");
  AST_RISE:
    assert property ($rose(irq_request_o) |-> $past(wr && avs_address_i == 8'h35)
      || $past(clock_ready_i, 2) || $past(clock_failure_i, 2)) else $error("stray irq");
  AST_RC_HOT:
    assert property (rd && avs_address_i == 8'h38 |-> $onehot(avs_readdata_o[7:0]))
      else $error("cause not one-hot");
  AST_RC_ZERO:
    assert property (rd && avs_address_i == 8'h38 |-> avs_readdata_o[31:7] == 25'h0
      && !avs_readdata_o[3]) else $error("cause reserved bits");
endmodule
bind pmcg_top pmcg_top_sva sva_u (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .clock_ready_i, .clock_failure_i, .access_guard_c_clk_en_o,
  .event_router_clk_en_o, .serial_unit_clk_en_o, .timer_unit_clk_en_o, .irq_request_o);

// *** test/pmcg_top_tb.sv ***
// self-checking bench for the power manager slice
// assumes: pmcg_top as declared; one wait cycle per bus transfer
`timescale 1ns/1ps
module pmcg_top_tb;
  logic        clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        clock_ready_i, clock_failure_i, irq_request_o, evt_irq_o, ag, er;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i, tm;
  logic [5:0]  sr, cause;
  integer      fails, checks_done;
  wire  [11:0] gates = {tm, sr, er, ag};
  pmcg_top dut_u (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .clock_ready_i, .clock_failure_i, .power_on_cause_i(cause[0]),
    .core_supply_brownout_i(cause[1]), .io_supply_brownout_i(cause[2]),
    .pin_reset_cause_i(cause[3]), .watchdog_cause_i(cause[4]),
    .software_reset_cause_i(cause[5]), .access_guard_c_clk_en_o(ag),
    .event_router_clk_en_o(er), .serial_unit_clk_en_o(sr),
    .timer_unit_clk_en_o(tm), .irq_request_o, .evt_irq_o);
  // 125 MHz clock
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // called just after a rising edge; request held until the rising edge
  // at which waitrequest is sampled low, read data taken at that edge;
  // left up for back-to-back use
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    if (n >= 50) fails++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic idle(input integer c);
    avs_read_i <= 0;
    avs_write_i <= 0;
    repeat (c) @(posedge clk_i);
  endtask
  task automatic reset_dut;
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic t_reset;
    rd(8'h38, 32'h1);
    rd(8'h34, 32'h0);
    rd(8'h36, 32'h0);
    rd(8'h7f, 32'h0);
    chk(gates, 32'h0);
  endtask
  task automatic t_mask;
    for (int i = 0; i < 12; i++) begin
      bus(1, 8'h20, 32'h1 << i);
      idle(1);
      chk(gates, 32'h1 << i);
    end
    avs_byteenable_i <= 4'h1;
    bus(1, 8'h20, 32'h0000_0fff);
    idle(1);
    avs_byteenable_i <= 4'hf;
    chk(gates, 32'h0000_08ff);
  endtask
  task automatic t_irq;
    clock_ready_i <= 1;
    idle(6);
    rd(8'h36, 32'h1);
    chk(irq_request_o, 0);
    rd(8'h40, 32'h1);
    bus(1, 8'h42, 32'h1);
    idle(1);
    chk(evt_irq_o, 1);
    bus(1, 8'h41, 32'h1);
    idle(1);
    chk(evt_irq_o, 0);
    bus(1, 8'h35, 32'h1);
    rd(8'h34, 32'h1);
    chk(irq_request_o, 1);
    bus(1, 8'h35, 32'h0);
    bus(1, 8'h34, 32'h0);
    rd(8'h35, 32'h1);
    bus(1, 8'h34, 32'h1);
    rd(8'h35, 32'h0);
    chk(irq_request_o, 0);
    bus(1, 8'h35, 32'h3);
    rd(8'h35, 32'h3);
    bus(1, 8'h36, 32'h0);
    rd(8'h36, 32'h1);
    bus(1, 8'h36, 32'h1);
    rd(8'h36, 32'h0);
    chk(irq_request_o, 0);
    clock_failure_i <= 1;
    idle(6);
    chk(irq_request_o, 1);
    bus(1, 8'h34, 32'h2);
    rd(8'h35, 32'h1);
    chk(irq_request_o, 0);
    bus(1, 8'h34, 32'h3);
    clock_ready_i <= 0;
    clock_failure_i <= 0;
    idle(4);
  endtask
  // each source alone, then two together: only one bit may survive
  task automatic t_cause;
    for (int i = 0; i < 6; i++) begin
      cause <= 6'h1 << i;
      reset_dut();
      cause <= 6'h0;
      rd(8'h38, 32'h1 << (i + (i > 2)));
      idle(1);
    end
    cause <= 6'h12;
    reset_dut();
    cause <= 6'h0;
    rd(8'h38, 32'h2);
    chk(gates, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    {avs_read_i, avs_write_i, clock_ready_i, clock_failure_i} <= 4'h0;
    avs_address_i <= 8'h0;
    avs_writedata_i <= 32'h0;
    avs_byteenable_i <= 4'hf;
    cause <= 6'h1;
    reset_dut();
    cause <= 6'h0;
    t_reset();
    idle(1);
    t_mask();
    t_irq();
    t_cause();
    tally_and_finish();
  end
  // hang guard, far beyond the two hundred or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
endmodule
